/* rtl/tsc_regs.svh */
// register offsets, bit positions, reset values and timing counts of the sensor control
`ifndef TSC_REGS_SVH
`define TSC_REGS_SVH

`define TSC_OFS_TEMP      32'h0000_0000
`define TSC_OFS_CFG       32'h0000_0004
`define TSC_OFS_THIGH     32'h0000_0008
`define TSC_OFS_TLOW      32'h0000_000C
`define TSC_OFS_GP1       32'h0000_0010
`define TSC_OFS_GP4       32'h0000_001C
`define TSC_OFS_UNLOCK    32'h0000_0020

`define TSC_NV_WORDS      7
`define TSC_IDX_CFG       3'h0
`define TSC_IDX_THIGH     3'h1
`define TSC_IDX_TLOW      3'h2

`define TSC_BIT_HIGH      15
`define TSC_BIT_LOW       14
`define TSC_BIT_READY     13
`define TSC_BIT_BUSY      1
`define TSC_BIT_UNLOCK    0

`define TSC_RST_TEMP      16'h8000
`define TSC_RST_THIGH     16'h6000
`define TSC_RST_TLOW      16'h8000
`define TSC_RST_CFG       16'h0088
`define TSC_RST_GP        16'h0000
`define TSC_GC_RESET_BYTE 8'h06

`define TSC_CLK_MHZ       125
`define TSC_LOAD_US       1500
`define TSC_PROG_US       7000
`define TSC_CYCLE_TIME_FIELD_US       15500
`define TSC_STBY_US       15500
`define TSC_LOAD_CYC      (`TSC_LOAD_US * `TSC_CLK_MHZ)
`define TSC_PROG_CYC      (`TSC_PROG_US * `TSC_CLK_MHZ)
`define TSC_CYCLE_TIME_FIELD_CYC      (`TSC_CYCLE_TIME_FIELD_US * `TSC_CLK_MHZ)
`define TSC_STBY_CYC      (`TSC_STBY_US * `TSC_CLK_MHZ)

`endif

/* rtl/tsc_pkg.sv */
// types shared by the temperature sensor control block
package tsc_pkg;

   typedef struct packed {
      logic [31:0] awaddr;
      logic        awvalid;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        wvalid;
      logic        bready;
      logic [31:0] araddr;
      logic        arvalid;
      logic        rready;
   } tsc_axi_req_t;

   typedef struct packed {
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } tsc_axi_rsp_t;

   typedef enum logic [1:0] {
      MODE_CONT  = 2'h0,
      MODE_DOWN  = 2'h1,
      MODE_ONCE  = 2'h2,
      MODE_CONTB = 2'h3
   } tsc_mode_t;

   typedef struct packed {
      tsc_mode_t  convMode;
      logic [2:0] cycleTime;
      logic [1:0] averaging;
      logic       styleThermo;
      logic       polHigh;
      logic       pinSrcReady;
   } tsc_cfg_t;

   typedef enum logic [1:0] {
      ST_LOAD   = 2'h0,
      ST_ACTIVE = 2'h1,
      ST_STBY   = 2'h3,
      ST_DOWN   = 2'h2
   } tsc_state_t;

endpackage

/* rtl/tsc_ctrl.sv */
// temperature sensor control: modes, flags, limit pin, nonvolatile shadow, AXI4-Lite slave
`timescale 1ns/10ps
`include "tsc_regs.svh"

module tsc_ctrl
   import tsc_pkg::*;
#(
   parameter int unsigned LOAD_CYC = `TSC_LOAD_CYC,
   parameter int unsigned PROG_CYC = `TSC_PROG_CYC,
   parameter int unsigned CYCLE_TIME_FIELD_CYC = `TSC_CYCLE_TIME_FIELD_CYC,
   parameter int unsigned STBY_CYC = `TSC_STBY_CYC
) (
   input  wire logic         core_clk,
   input  wire logic         sys_rst,
   input  wire tsc_axi_req_t axiReq,
   output tsc_axi_rsp_t      axiRsp,
   input  wire logic [15:0]  sensorData,
   input  wire logic         gcStrobe,
   input  wire logic [7:0]   gcByte,
   input  wire logic         alertRespCmd,
   output logic             limitPinOut,
   output logic             limitPinOe
);

   // byte-lane merge of a 16-bit register
   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                           input logic [3:0] st);
      merge16 = old;
      if (st[0]) begin
         merge16[7:0] = wd[7:0];
      end
      if (st[1]) begin
         merge16[15:8] = wd[15:8];
      end
   endfunction

   function automatic logic hotter(input logic [15:0] a, input logic [15:0] b);
      hotter = $signed(a) > $signed(b);
   endfunction

   // word index of a shadowed register, or 7 when none
   function automatic logic [2:0] nvIndex(input logic [31:0] addr);
      if (addr >= `TSC_OFS_CFG && addr <= `TSC_OFS_GP4 && addr[1:0] == 2'h0) begin
         nvIndex = 3'(addr[4:2] - 3'h1);
      end else begin
         nvIndex = 3'h7;
      end
   endfunction

   function automatic logic [31:0] avgCount(input logic [1:0] averaging_field);
      case (averaging_field)
         2'h0:    avgCount = 32'h1;
         2'h1:    avgCount = 32'h8;
         2'h2:    avgCount = 32'h20;
         default: avgCount = 32'h40;
      endcase
   endfunction

   logic [15:0] volQ [0:`TSC_NV_WORDS-1];
   logic [15:0] nvQ  [0:`TSC_NV_WORDS-1];
   logic [15:0] temp_q;
   logic        unlock_q;
   logic        loadActive_q;
   logic        progActive_q;
   logic [31:0] nvCnt_q;
   tsc_state_t  state_q;
   logic [31:0] cnt_q;
   logic        oneShot_q;
   logic        highFlag_q;
   logic        lowFlag_q;
   logic        dataReady_q;
   logic        alertLatch_q;
   logic        awready_q;
   logic        wready_q;
   logic        bvalid_q;
   logic [1:0]  bresp_q;
   logic        arready_q;
   logic        rvalid_q;
   logic [31:0] rdata_q;
   logic [1:0]  rresp_q;
   logic        pinOut_q;
   logic        pinOe_q;

   tsc_cfg_t    cfg;
   logic        wrEn;
   logic        rdEn;
   logic [2:0]  wrIdx;
   logic [15:0] wrVal;
   logic        cfgRd;
   logic        tempRd;
   logic        gcHit;
   logic        convEnd;
   logic        abortReq;
   logic        nvBusy;
   logic [31:0] activeCyc;
   logic [31:0] stbyCyc;
   logic        pinAct;

   assign cfg       = tsc_cfg_t'(volQ[`TSC_IDX_CFG][9:0]);
   assign wrEn      = awready_q && axiReq.awvalid && axiReq.wvalid;
   assign rdEn      = arready_q && axiReq.arvalid;
   assign wrIdx     = nvIndex(axiReq.awaddr);
   assign wrVal     = merge16(volQ[wrIdx], axiReq.wdata, axiReq.wstrb);
   assign cfgRd     = rdEn && axiReq.araddr == `TSC_OFS_CFG;
   assign tempRd    = rdEn && axiReq.araddr == `TSC_OFS_TEMP;
   assign gcHit     = gcStrobe && gcByte == `TSC_GC_RESET_BYTE;
   assign abortReq  = cfg.convMode == MODE_DOWN;
   assign convEnd   = state_q == ST_ACTIVE && cnt_q == 32'h0 && !abortReq;
   assign nvBusy    = loadActive_q || progActive_q;
   assign activeCyc = 32'(CYCLE_TIME_FIELD_CYC * avgCount(cfg.averaging));
   assign stbyCyc   = 32'(STBY_CYC << cfg.cycleTime);

   // shadow memory, power-on load and programming timer
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         nvQ[`TSC_IDX_CFG]   <= `TSC_RST_CFG;
         nvQ[`TSC_IDX_THIGH] <= `TSC_RST_THIGH;
         nvQ[`TSC_IDX_TLOW]  <= `TSC_RST_TLOW;
         for (int i = 3; i < `TSC_NV_WORDS; i++) begin
            nvQ[i] <= `TSC_RST_GP;
         end
         unlock_q     <= 1'b0;
         loadActive_q <= 1'b1;
         progActive_q <= 1'b0;
         nvCnt_q      <= 32'(LOAD_CYC - 1);
      end else if (gcHit) begin
         unlock_q     <= 1'b0;
         loadActive_q <= 1'b1;
         progActive_q <= 1'b0;
         nvCnt_q      <= 32'(LOAD_CYC - 1);
      end else begin
         if (nvBusy) begin
            if (nvCnt_q == 32'h0) begin
               loadActive_q <= 1'b0;
               progActive_q <= 1'b0;
            end else begin
               nvCnt_q <= nvCnt_q - 32'h1;
            end
         end
         if (wrEn && axiReq.awaddr == `TSC_OFS_UNLOCK && axiReq.wstrb[0]) begin
            unlock_q <= axiReq.wdata[`TSC_BIT_UNLOCK];
         end
         if (wrEn && wrIdx != 3'h7 && unlock_q && !loadActive_q) begin
            nvQ[wrIdx]   <= wrVal;
            progActive_q <= 1'b1;
            nvCnt_q      <= 32'(PROG_CYC - 1);
         end
      end
   end

   // volatile register copies
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         volQ[`TSC_IDX_CFG]   <= `TSC_RST_CFG;
         volQ[`TSC_IDX_THIGH] <= `TSC_RST_THIGH;
         volQ[`TSC_IDX_TLOW]  <= `TSC_RST_TLOW;
         for (int i = 3; i < `TSC_NV_WORDS; i++) begin
            volQ[i] <= `TSC_RST_GP;
         end
      end else if (gcHit) begin
         for (int i = 0; i < `TSC_NV_WORDS; i++) begin
            volQ[i] <= nvQ[i];
         end
      end else begin
         if (convEnd && oneShot_q) begin
            volQ[`TSC_IDX_CFG][9:8] <= MODE_DOWN;
         end
         if (wrEn && wrIdx != 3'h7 && !(loadActive_q && wrIdx <= `TSC_IDX_TLOW)) begin
            volQ[wrIdx] <= wrVal;
         end
      end
   end

   // conversion sequencer
   always_ff @(posedge core_clk) begin
      if (sys_rst || gcHit) begin
         state_q   <= ST_LOAD;
         cnt_q     <= 32'h0;
         oneShot_q <= 1'b0;
         temp_q    <= `TSC_RST_TEMP;
      end else begin
         case (state_q)
            ST_LOAD: begin
               if (!loadActive_q) begin
                  state_q <= cfg.convMode == MODE_DOWN ? ST_DOWN : ST_ACTIVE;
                  cnt_q   <= activeCyc - 32'h1;
               end
            end
            ST_ACTIVE: begin
               if (abortReq) begin
                  state_q   <= ST_DOWN;
                  oneShot_q <= 1'b0;
               end else if (cnt_q == 32'h0) begin
                  temp_q <= sensorData;
                  if (oneShot_q) begin
                     state_q   <= ST_DOWN;
                     oneShot_q <= 1'b0;
                  end else begin
                     state_q <= ST_STBY;
                     cnt_q   <= stbyCyc - 32'h1;
                  end
               end else begin
                  cnt_q <= cnt_q - 32'h1;
               end
            end
            ST_STBY: begin
               if (abortReq) begin
                  state_q <= ST_DOWN;
               end else if (cnt_q == 32'h0) begin
                  state_q <= ST_ACTIVE;
                  cnt_q   <= activeCyc - 32'h1;
               end else begin
                  cnt_q <= cnt_q - 32'h1;
               end
            end
            ST_DOWN: begin
               if (cfg.convMode != MODE_DOWN) begin
                  state_q   <= ST_ACTIVE;
                  oneShot_q <= cfg.convMode == MODE_ONCE;
                  cnt_q     <= activeCyc - 32'h1;
               end
            end
            default: state_q <= ST_LOAD;
         endcase
      end
   end

   // status flags; a conversion event wins over a clearing read
   always_ff @(posedge core_clk) begin
      if (sys_rst || gcHit) begin
         highFlag_q   <= 1'b0;
         lowFlag_q    <= 1'b0;
         dataReady_q  <= 1'b0;
         alertLatch_q <= 1'b0;
      end else begin
         if (convEnd) begin
            dataReady_q <= 1'b1;
         end else if (cfgRd || tempRd) begin
            dataReady_q <= 1'b0;
         end
         if (cfg.styleThermo) begin
            lowFlag_q <= 1'b0;
            if (convEnd && hotter(sensorData, volQ[`TSC_IDX_THIGH])) begin
               highFlag_q <= 1'b1;
            end else if (convEnd && hotter(volQ[`TSC_IDX_TLOW], sensorData)) begin
               highFlag_q <= 1'b0;
            end
         end else begin
            if (convEnd && hotter(sensorData, volQ[`TSC_IDX_THIGH])) begin
               highFlag_q <= 1'b1;
            end else if (cfgRd) begin
               highFlag_q <= 1'b0;
            end
            if (convEnd && hotter(volQ[`TSC_IDX_TLOW], sensorData)) begin
               lowFlag_q <= 1'b1;
            end else if (cfgRd) begin
               lowFlag_q <= 1'b0;
            end
         end
         if (convEnd && (hotter(sensorData, volQ[`TSC_IDX_THIGH])
                         || hotter(volQ[`TSC_IDX_TLOW], sensorData))) begin
            alertLatch_q <= 1'b1;
         end else if (cfgRd || alertRespCmd) begin
            alertLatch_q <= 1'b0;
         end
      end
   end

   // limit pin: open drain, pulled up when released
   assign pinAct = cfg.pinSrcReady ? dataReady_q :
                   cfg.styleThermo ? highFlag_q : alertLatch_q;

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         pinOut_q <= 1'b1;
         pinOe_q  <= 1'b0;
      end else begin
         pinOut_q <= cfg.polHigh ? pinAct : !pinAct;
         pinOe_q  <= cfg.polHigh ? !pinAct : pinAct;
      end
   end

   // AXI4-Lite write channel
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         awready_q <= 1'b0;
         wready_q  <= 1'b0;
         bvalid_q  <= 1'b0;
         bresp_q   <= 2'h0;
      end else begin
         awready_q <= !awready_q && !bvalid_q && axiReq.awvalid && axiReq.wvalid;
         wready_q  <= !awready_q && !bvalid_q && axiReq.awvalid && axiReq.wvalid;
         if (wrEn) begin
            bvalid_q <= 1'b1;
            bresp_q  <= (wrIdx != 3'h7 || axiReq.awaddr == `TSC_OFS_UNLOCK) ? 2'h0 : 2'h2;
         end else if (axiReq.bready) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   // AXI4-Lite read channel
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         arready_q <= 1'b0;
         rvalid_q  <= 1'b0;
         rdata_q   <= 32'h0000_0000;
         rresp_q   <= 2'h0;
      end else begin
         arready_q <= !arready_q && !rvalid_q && axiReq.arvalid;
         if (rdEn) begin
            rvalid_q <= 1'b1;
            rresp_q  <= 2'h0;
            rdata_q  <= 32'h0000_0000;
            if (axiReq.araddr == `TSC_OFS_TEMP) begin
               rdata_q[15:0] <= temp_q;
            end else if (axiReq.araddr == `TSC_OFS_CFG) begin
               rdata_q[9:0]              <= volQ[`TSC_IDX_CFG][9:0];
               rdata_q[`TSC_BIT_HIGH]    <= highFlag_q;
               rdata_q[`TSC_BIT_LOW]     <= lowFlag_q;
               rdata_q[`TSC_BIT_READY]   <= dataReady_q;
            end else if (axiReq.araddr == `TSC_OFS_UNLOCK) begin
               rdata_q[`TSC_BIT_BUSY]    <= nvBusy;
               rdata_q[`TSC_BIT_UNLOCK]  <= unlock_q;
            end else if (nvIndex(axiReq.araddr) != 3'h7) begin
               rdata_q[15:0] <= volQ[nvIndex(axiReq.araddr)];
            end else begin
               rresp_q <= 2'h2;
            end
         end else if (axiReq.rready) begin
            rvalid_q <= 1'b0;
         end
      end
   end

   assign axiRsp.awready = awready_q;
   assign axiRsp.wready  = wready_q;
   assign axiRsp.bvalid  = bvalid_q;
   assign axiRsp.bresp   = bresp_q;
   assign axiRsp.arready = arready_q;
   assign axiRsp.rvalid  = rvalid_q;
   assign axiRsp.rdata   = rdata_q;
   assign axiRsp.rresp   = rresp_q;
   assign limitPinOut    = pinOut_q;
   assign limitPinOe     = pinOe_q;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);

   sequence s_oneShotEnd;
      convEnd && oneShot_q && !gcHit && !wrEn;
   endsequence

   property p_oneShotDown;
      s_oneShotEnd |=> state_q == ST_DOWN && cfg.convMode == MODE_DOWN;
   endproperty
   a_oneShotDown: assert property (p_oneShotDown) else $error("one-shot did not power down");

   property p_contStandby;
      convEnd && !oneShot_q && !gcHit |=> state_q == ST_STBY;
   endproperty
   a_contStandby: assert property (p_contStandby) else $error("no standby after conversion");

   property p_resultUpdate;
      convEnd && !gcHit |=> temp_q == $past(sensorData);
   endproperty
   a_resultUpdate: assert property (p_resultUpdate) else $error("result not updated");

   property p_readySet;
      convEnd && !gcHit |=> dataReady_q;
   endproperty
   a_readySet: assert property (p_readySet) else $error("done flag not set");

   property p_readyClr;
      (cfgRd || tempRd) && !convEnd |=> !dataReady_q;
   endproperty
   a_readyClr: assert property (p_readyClr) else $error("done flag not cleared by read");

   property p_abort;
      state_q == ST_ACTIVE && abortReq && !gcHit |=> state_q == ST_DOWN;
   endproperty
   a_abort: assert property (p_abort) else $error("power-down did not abort");

   property p_highSet;
      convEnd && !gcHit && hotter(sensorData, volQ[`TSC_IDX_THIGH]) |=> highFlag_q;
   endproperty
   a_highSet: assert property (p_highSet) else $error("upper flag not set");

   property p_thermoRead;
      cfg.styleThermo && cfgRd && !convEnd && !gcHit |=> $stable(highFlag_q);
   endproperty
   a_thermoRead: assert property (p_thermoRead) else $error("thermostat flag changed by read");

   property p_loadIgnore;
      wrEn && loadActive_q && wrIdx == `TSC_IDX_THIGH && !gcHit |=> $stable(volQ[1]);
   endproperty
   a_loadIgnore: assert property (p_loadIgnore) else $error("write taken during load");

   property p_gcReset;
      gcHit |=> loadActive_q && !unlock_q && state_q == ST_LOAD;
   endproperty
   a_gcReset: assert property (p_gcReset) else $error("general call did not reload");

   property p_pinLevel;
      ##1 1'b1 |-> limitPinOut == ($past(cfg.polHigh) ? $past(pinAct) : !$past(pinAct));
   endproperty
   a_pinLevel: assert property (p_pinLevel) else $error("pin level wrong");

endmodule

/* verif/tsc_host_model.sv */
// AXI4-Lite master standing in for the bus host
`timescale 1ns/10ps
module tsc_host_model
   import tsc_pkg::*;
(
   input  wire logic         core_clk,
   output tsc_axi_req_t      axiReq,
   input  wire tsc_axi_rsp_t axiRsp
);
   initial axiReq = '0;

   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      @(posedge core_clk);
      axiReq.awaddr  <= a;
      axiReq.wdata   <= d;
      axiReq.wstrb   <= 4'hF;
      axiReq.awvalid <= 1'b1;
      axiReq.wvalid  <= 1'b1;
      axiReq.bready  <= 1'b1;
      do begin
         @(posedge core_clk);
         if (axiRsp.awready === 1'b1) begin
            axiReq.awvalid <= 1'b0;
            axiReq.awaddr  <= ~a;
         end
         if (axiRsp.wready === 1'b1) begin
            axiReq.wvalid <= 1'b0;
            axiReq.wdata  <= ~d;
         end
      end while (axiRsp.bvalid !== 1'b1);
      axiReq.bready <= 1'b0;
   endtask

   task automatic rd(input logic [31:0] a, output logic [31:0] d);
      @(posedge core_clk);
      axiReq.araddr  <= a;
      axiReq.arvalid <= 1'b1;
      axiReq.rready  <= 1'b1;
      do begin
         @(posedge core_clk);
         if (axiRsp.arready === 1'b1) begin
            axiReq.arvalid <= 1'b0;
            axiReq.araddr  <= ~a;
         end
      end while (axiRsp.rvalid !== 1'b1);
      d = axiRsp.rdata;
      axiReq.rready <= 1'b0;
   endtask
endmodule

/* verif/tb_top.sv */
// self-checking bench of the sensor control block
`timescale 1ns/10ps
`include "tsc_regs.svh"
`define CHK(nm, e, s) begin cmp_count++; if ((s) !== (e)) begin n_mismatch++; \
   $display("[FAIL] %s exp %h seen %h", nm, e, s); end end
module tb_top
   import tsc_pkg::*;
();
   logic         core_clk     = 1'b0;
   logic         sys_rst      = 1'b1;
   tsc_axi_req_t axiReq;
   tsc_axi_rsp_t axiRsp;
   logic [15:0]  sensorData   = 16'h0000;
   logic         gcStrobe     = 1'b0;
   logic [7:0]   gcByte       = 8'h00;
   logic         alertRespCmd = 1'b0;
   logic         limitPinOut;
   logic         limitPinOe;
   logic [31:0]  rng          = 32'hBDE37180;
   logic [31:0]  rdv;
   logic [65:0]  nt;
   logic [1:0]   wn;
   int           polls;
   int           n_mismatch   = 0;
   int           cmp_count    = 0;
   logic [65:0]  rdQ[$];
   logic [1:0]   wrQ[$];
   wire          pinLevel     = limitPinOe ? 1'b0 : 1'b1;

   always #4 core_clk = ~core_clk;

   tsc_ctrl #(.LOAD_CYC (20), .PROG_CYC (30), .CYCLE_TIME_FIELD_CYC (10), .STBY_CYC (8)) u_dut (
      .core_clk     (core_clk),
      .sys_rst      (sys_rst),
      .axiReq       (axiReq),
      .axiRsp       (axiRsp),
      .sensorData   (sensorData),
      .gcStrobe     (gcStrobe),
      .gcByte       (gcByte),
      .alertRespCmd (alertRespCmd),
      .limitPinOut  (limitPinOut),
      .limitPinOe   (limitPinOe)
   );
   tsc_host_model u_host (.core_clk (core_clk), .axiReq (axiReq), .axiRsp (axiRsp));

   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction

   // mask 0 marks a poll whose data is not judged
   task automatic rdc(input logic [31:0] a, input logic [31:0] e = 0,
                      input logic [31:0] m = 32'hFFFF, input logic [1:0] r = 2'b00);
      rdQ.push_back({r, m, e});
      u_host.rd(a, rdv);
   endtask
   task automatic wrc(input logic [31:0] a, input logic [31:0] d,
                      input logic [1:0] r = 2'b00);
      wrQ.push_back(r);
      u_host.wr(a, d);
   endtask
   task automatic waitRes(input logic [15:0] v);
      polls = 0;
      do begin
         rdc(`TSC_OFS_TEMP, 0, 0);
         polls++;
      end while (rdv[15:0] !== v && polls < 100);
      `CHK("result", v, rdv[15:0])
   endtask
   task automatic waitIdle;
      int n;
      n = 0;
      do begin
         rdc(`TSC_OFS_UNLOCK, 0, 0);
         n++;
      end while (rdv[`TSC_BIT_BUSY] !== 1'b0 && n < 100);
      `CHK("busy", 1'b0, rdv[`TSC_BIT_BUSY])
   endtask
   task automatic shot(input logic [7:0] c, input logic [15:0] s);
      sensorData <= s;
      wrc(`TSC_OFS_CFG, {22'h0, 2'b01, c});
      wrc(`TSC_OFS_CFG, {22'h0, 2'b10, c});
   endtask
   task automatic pinChk(input logic e);
      repeat (3) @(posedge core_clk);
      `CHK("pin", e, pinLevel)
   endtask
   task automatic pulse(input logic g, input logic [7:0] b);
      @(posedge core_clk);
      gcByte       <= b;
      gcStrobe     <= g;
      alertRespCmd <= ~g;
      @(posedge core_clk);
      gcStrobe     <= 1'b0;
      alertRespCmd <= 1'b0;
   endtask
   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // result checker: oldest note against each answer
   always @(posedge core_clk) begin
      if (axiRsp.rvalid === 1'b1 && axiReq.rready === 1'b1 && rdQ.size() > 0) begin
         nt = rdQ.pop_front();
         `CHK("rresp", nt[65:64], axiRsp.rresp)
         if (nt[63:32] != 0)
            `CHK("rdata", nt[31:0], axiRsp.rdata & nt[63:32])
      end
      if (axiRsp.bvalid === 1'b1 && axiReq.bready === 1'b1 && wrQ.size() > 0) begin
         wn = wrQ.pop_front();
         `CHK("bresp", wn, axiRsp.bresp)
      end
   end

   initial begin
      #200000;
      n_mismatch++;
      give_verdict;
   end

   initial begin
      repeat (20) @(posedge core_clk);
      sys_rst <= 1'b0;
      wrc(`TSC_OFS_THIGH, 32'h1234);
      rdc(`TSC_OFS_UNLOCK, 32'h2, 32'h3);
      rdc(`TSC_OFS_THIGH, {16'h0, `TSC_RST_THIGH});
      rdc(`TSC_OFS_TLOW, {16'h0, `TSC_RST_TLOW});
      rdc(`TSC_OFS_TEMP, {16'h0, `TSC_RST_TEMP});
      rdc(`TSC_OFS_CFG, {16'h0, `TSC_RST_CFG}, 32'h3FF);
      waitIdle;
      rdc(32'h40, 0, 32'hFFFFFFFF, 2'b10);
      wrc(`TSC_OFS_TEMP, 32'h0, 2'b10);
      wrc(32'h44, 32'h0, 2'b10);
      $display("test load and refusals done");
      wrc(`TSC_OFS_CFG, 32'h0100);
      wrc(`TSC_OFS_TLOW, 32'h0);
      wrc(`TSC_OFS_THIGH, 32'h0100);
      shot(8'hE0, 16'h0200);
      waitRes(16'h0200);
      `CHK("polls", 1'b1, (polls <= 6))
      pinChk(1'b0);
      rdc(`TSC_OFS_CFG, 32'h81E0, 32'hC3FF);
      rdc(`TSC_OFS_CFG, 32'h0, 32'hC000);
      pinChk(1'b1);
      sensorData <= 16'h0300;
      repeat (100) @(posedge core_clk);
      rdc(`TSC_OFS_TEMP, 32'h0200);
      shot(8'h02, 16'hFF00);
      waitRes(16'hFF00);
      pinChk(1'b1);
      pulse(1'b0, 8'h00);
      pinChk(1'b0);
      rdc(`TSC_OFS_CFG, 32'h4000, 32'hC000);
      $display("test window style done");
      shot(8'h04, 16'h0200);
      waitRes(16'h0200);
      rdc(`TSC_OFS_CFG, 32'h8000, 32'hC000);
      pulse(1'b0, 8'h00);
      pinChk(1'b0);
      shot(8'h04, 16'h0050);
      waitRes(16'h0050);
      rdc(`TSC_OFS_CFG, 32'h8000, 32'hC000);
      shot(8'h04, 16'hFF00);
      waitRes(16'hFF00);
      rdc(`TSC_OFS_CFG, 32'h0, 32'hC000);
      pinChk(1'b1);
      $display("test thermostat style done");
      rng = xs(rng);
      shot(8'h01, {5'h0, rng[10:0]});
      repeat (20) @(posedge core_clk);
      pinChk(1'b0);
      rdc(`TSC_OFS_TEMP, {21'h0, rng[10:0]});
      pinChk(1'b1);
      sensorData <= 16'h0011;
      wrc(`TSC_OFS_CFG, 32'h0000);
      waitRes(16'h0011);
      sensorData <= 16'h0022;
      waitRes(16'h0022);
      wrc(`TSC_OFS_CFG, 32'h0018);
      repeat (50) @(posedge core_clk);
      sensorData <= 16'h0033;
      wrc(`TSC_OFS_CFG, 32'h0118);
      repeat (700) @(posedge core_clk);
      rdc(`TSC_OFS_TEMP, 32'h0022);
      $display("test done flag and modes done");
      rng = xs(rng);
      wrc(`TSC_OFS_GP1, {16'h0, rng[15:0]});
      rdc(`TSC_OFS_GP1, {16'h0, rng[15:0]});
      wrc(`TSC_OFS_THIGH, 32'h0111);
      pulse(1'b1, 8'h05);
      rdc(`TSC_OFS_THIGH, 32'h0111);
      pulse(1'b1, `TSC_GC_RESET_BYTE);
      waitIdle;
      rdc(`TSC_OFS_GP1, 32'h0);
      rdc(`TSC_OFS_THIGH, {16'h0, `TSC_RST_THIGH});
      wrc(`TSC_OFS_UNLOCK, 32'h1);
      wrc(`TSC_OFS_GP4, 32'hA5C3);
      rdc(`TSC_OFS_UNLOCK, 32'h3, 32'h3);
      waitIdle;
      wrc(`TSC_OFS_THIGH, 32'h0222);
      waitIdle;
      pulse(1'b1, `TSC_GC_RESET_BYTE);
      waitIdle;
      rdc(`TSC_OFS_THIGH, 32'h0222);
      rdc(`TSC_OFS_GP4, 32'hA5C3);
      rdc(`TSC_OFS_UNLOCK, 32'h0, 32'h1);
      $display("test shadow memory done");
      give_verdict;
   end
endmodule
